// [src/sic_defines.vh]
// Offsets, field positions and reset values of the socket status-change block.
`ifndef SIC_DEFINES_VH
`define SIC_DEFINES_VH
// ***********************************************
// Register byte addresses
// ***********************************************
`define SIC_ADDR_CTRL    4'h0
`define SIC_ADDR_FLAGS   4'h4
`define SIC_ADDR_CFG     4'h8
// ***********************************************
// Control register fields
// ***********************************************
`define SIC_CTL_RING     7
`define SIC_CTL_RESET    6
`define SIC_CTL_KIND     5
`define SIC_CTL_ROUTE    4
`define SIC_CTL_SEL_HI   3
`define SIC_CTL_SEL_LO   0
`define SIC_CTL_RST_VAL  8'h00
// ***********************************************
// Flag register fields
// ***********************************************
`define SIC_FLG_DETECT   3
`define SIC_FLG_READY    2
`define SIC_FLG_BATLOW   1
`define SIC_FLG_BATTERY_DEAD_FLAG  0
`define SIC_FLG_RST_VAL  4'h0
// ***********************************************
// Configuration register fields
// ***********************************************
`define SIC_CFG_ENA_HI   3
`define SIC_CFG_ENA_LO   0
`define SIC_CFG_SEL_HI   7
`define SIC_CFG_SEL_LO   4
`define SIC_CFG_DIAG     8
`define SIC_CFG_W1C      9
`define SIC_CFG_PME      10
`define SIC_CFG_WIDTH    11
`define SIC_CFG_RST_VAL  11'h000
`define SIC_SEL_NONE     4'h0
`endif

// [src/sic_socket_irq.v]
// Socket interrupt control and card status-change flags behind an Avalon-MM slave.
`timescale 1ns/1ns
`include "sic_defines.vh"

module sic_socket_irq
(
  // Clock and reset.
  input  wire        mclk,
  input  wire        resetn,
  // Avalon-MM register slave.
  input  wire [3:0]  avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output wire [31:0] avsReadData,
  output wire        avsWaitRequest,
  // System reset pins, active high.
  input  wire        globalResetPin,
  input  wire        busResetPin,
  // Card socket inputs.
  input  wire        cardDetectOneN,
  input  wire        cardDetectTwoN,
  input  wire        cardReady,
  input  wire        batteryVoltageOne,
  input  wire        batteryVoltageTwo,
  input  wire        cardStatusLineN,
  input  wire        cardIrqN,
  // Card and interrupt outputs.
  output wire        cardResetOut,
  output wire        changeIrqPci,
  output wire [15:0] changeIrqLines,
  output wire [15:0] funcIrqLines
);

  // ***********************************************
  // Storage
  // ***********************************************
  reg  [7:0]                ctrl_ff;      // Interrupt and general control.
  reg  [3:0]                flags_ff;     // Sticky status-change flags.
  reg  [`SIC_CFG_WIDTH-1:0] cfg_ff;       // Enables, routing and clear mode.
  reg                       wait_ff;      // Waitrequest, high when idle.
  reg  [31:0]               rdData_ff;    // Captured read data.
  reg  [1:0]                detPrev_ff;   // Last card detect levels.
  reg                       rdyPrev_ff;   // Last ready level.
  reg                       lowPrev_ff;   // Last battery-low condition.
  reg                       cardRst_ff;   // Card reset drive.
  reg                       irqPci_ff;    // Change interrupt to PCI.
  reg  [15:0]               irqLines_ff;  // Change interrupt to IRQ/SMI.
  reg  [15:0]               funcLines_ff; // Card functional interrupt lines.

  // Decoded controls.
  wire       ringEna   = ctrl_ff[`SIC_CTL_RING];
  wire       ioCard    = ctrl_ff[`SIC_CTL_KIND];
  wire [3:0] funcSel   = ctrl_ff[`SIC_CTL_SEL_HI:`SIC_CTL_SEL_LO];
  wire [3:0] srcEna    = cfg_ff[`SIC_CFG_ENA_HI:`SIC_CFG_ENA_LO];
  wire [3:0] chgSel    = cfg_ff[`SIC_CFG_SEL_HI:`SIC_CFG_SEL_LO];
  wire       diagRoute = cfg_ff[`SIC_CFG_DIAG];
  wire       w1cMode   = cfg_ff[`SIC_CFG_W1C];
  wire       pmeEna    = cfg_ff[`SIC_CFG_PME];

  // ***********************************************
  // Reset scopes
  // ***********************************************
  // Context state survives a bus reset while power management is enabled,
  // so that a wake event is not lost across the bus reset.
  wire ctxClear = globalResetPin | (~pmeEna & busResetPin);
  wire anyClear = globalResetPin | busResetPin;

  // ***********************************************
  // Bus decode
  // ***********************************************
  // A request commits on the edge where waitrequest is seen low.
  wire       commit  = ~wait_ff;
  wire       wrDo    = commit & avsWrite & avsByteEnable[0];
  wire       wrDoHi  = commit & avsWrite & avsByteEnable[1];
  wire       rdDo    = commit & avsRead;
  wire       selCtrl = (avsAddress == `SIC_ADDR_CTRL);
  wire       selFlg  = (avsAddress == `SIC_ADDR_FLAGS);
  wire       selCfg  = (avsAddress == `SIC_ADDR_CFG);

  // ***********************************************
  // Event detection
  // ***********************************************
  // Sources are gated by their enables so a masked source never sets.
  wire [3:0] evt;
  wire       lowNow = batteryVoltageOne & ~batteryVoltageTwo;
  assign evt[`SIC_FLG_DETECT] =
    ({cardDetectTwoN, cardDetectOneN} != detPrev_ff);
  assign evt[`SIC_FLG_READY] = ~ioCard & cardReady & ~rdyPrev_ff;
  assign evt[`SIC_FLG_BATLOW] = ~ioCard & lowNow & ~lowPrev_ff;
  // The status line shares the ring pin; in ring mode it is the ring.
  assign evt[`SIC_FLG_BATTERY_DEAD_FLAG] = ~cardStatusLineN;
  wire [3:0] setEvt = evt & srcEna;

  // Visible flags: masked and card-kind gated bits always read zero.
  reg  [3:0] flagView;
  always @*
  begin
    flagView = flags_ff & srcEna;
    if (ioCard)
    begin
      // Ready and battery-low flags have no meaning for IO cards.
      flagView[`SIC_FLG_READY]  = 1'b0;
      flagView[`SIC_FLG_BATLOW] = 1'b0;
    end
    if (ringEna)
    begin
      // Ring mode shows the live ring line rather than a latch.
      flagView[`SIC_FLG_BATTERY_DEAD_FLAG] = srcEna[`SIC_FLG_BATTERY_DEAD_FLAG] &
                                   ~cardStatusLineN;
    end
  end

  // Clear mask: read-clear or write-one-clear, never both.
  reg  [3:0] clrMask;
  always @*
  begin
    clrMask = 4'h0;
    if (selFlg)
    begin
      if (w1cMode)
      begin
        if (wrDo)
        begin
          clrMask = avsWriteData[3:0];
        end
      end
      else if (rdDo)
      begin
        clrMask = 4'hF;
      end
    end
  end

  // ***********************************************
  // Flags and edge history
  // ***********************************************
  // A set arriving with a clear wins so no event is lost.
  wire [3:0] nxt_flags = (flags_ff & ~clrMask) | setEvt;

  always @(posedge mclk)
  begin
    if (!resetn || ctxClear)
    begin
      flags_ff <= `SIC_FLG_RST_VAL;
    end
    else
    begin
      flags_ff <= nxt_flags;
    end
  end

  // History for edge detection.
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      detPrev_ff <= 2'h3;
      rdyPrev_ff <= 1'b0;
      lowPrev_ff <= 1'b0;
    end
    else
    begin
      detPrev_ff <= {cardDetectTwoN, cardDetectOneN};
      rdyPrev_ff <= cardReady;
      lowPrev_ff <= lowNow;
    end
  end

  // ***********************************************
  // Control and configuration registers
  // ***********************************************
  // Reset and kind bits use the context scope; the rest any reset.
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      ctrl_ff <= `SIC_CTL_RST_VAL;
    end
    else
    begin
      if (ctxClear)
      begin
        ctrl_ff[`SIC_CTL_RESET] <= 1'b0;
        ctrl_ff[`SIC_CTL_KIND]  <= 1'b0;
      end
      else if (wrDo && selCtrl)
      begin
        ctrl_ff[`SIC_CTL_RESET] <= avsWriteData[`SIC_CTL_RESET];
        ctrl_ff[`SIC_CTL_KIND]  <= avsWriteData[`SIC_CTL_KIND];
      end
      if (anyClear)
      begin
        ctrl_ff[`SIC_CTL_RING]  <= 1'b0;
        ctrl_ff[`SIC_CTL_ROUTE] <= 1'b0;
        ctrl_ff[3:0]            <= 4'h0;
      end
      else if (wrDo && selCtrl)
      begin
        ctrl_ff[`SIC_CTL_RING]  <= avsWriteData[`SIC_CTL_RING];
        ctrl_ff[`SIC_CTL_ROUTE] <= avsWriteData[`SIC_CTL_ROUTE];
        ctrl_ff[3:0]            <= avsWriteData[3:0];
      end
    end
  end

  // The power-management enable itself is held across bus reset.
  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      cfg_ff <= `SIC_CFG_RST_VAL;
    end
    else
    begin
      if (globalResetPin)
      begin
        cfg_ff[`SIC_CFG_PME] <= 1'b0;
      end
      else if (wrDoHi && selCfg)
      begin
        cfg_ff[`SIC_CFG_PME] <= avsWriteData[`SIC_CFG_PME];
      end
      if (anyClear)
      begin
        cfg_ff[9:0] <= 10'h000;
      end
      else
      begin
        if (wrDo && selCfg)
        begin
          cfg_ff[7:0] <= avsWriteData[7:0];
        end
        if (wrDoHi && selCfg)
        begin
          cfg_ff[9:8] <= avsWriteData[9:8];
        end
      end
    end
  end

  // ***********************************************
  // Avalon-MM handshake
  // ***********************************************
  // Every access costs one wait state; this keeps read data and the
  // clear-on-read side effect on registered, glitch-free paths.
  reg  [31:0] rdMux;
  always @*
  begin
    rdMux = 32'h0000_0000;
    if (selCtrl)
    begin
      rdMux[7:0] = ctrl_ff;
    end
    else if (selFlg)
    begin
      rdMux[3:0] = flagView;
    end
    else if (selCfg)
    begin
      rdMux[`SIC_CFG_WIDTH-1:0] = cfg_ff;
    end
  end

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      wait_ff   <= 1'b1;
      rdData_ff <= 32'h0000_0000;
    end
    else
    begin
      wait_ff <= ~((avsRead | avsWrite) & wait_ff);
      if (avsRead && wait_ff)
      begin
        rdData_ff <= rdMux;
      end
    end
  end

  // ***********************************************
  // Interrupt routing
  // ***********************************************
  // Interrupt level stays high while any visible flag is set.
  wire pending = |flagView;
  // Diagnostic routing overrides the legacy route bit.
  wire toPci = diagRoute ? (chgSel == `SIC_SEL_NONE)
             : (ctrl_ff[`SIC_CTL_ROUTE] |
                (funcSel == `SIC_SEL_NONE));
  wire [3:0] isaSel = chgSel;

  always @(posedge mclk)
  begin
    if (!resetn)
    begin
      irqPci_ff  <= 1'b0;
      cardRst_ff <= 1'b1;
    end
    else
    begin
      irqPci_ff  <= pending & toPci;
      cardRst_ff <= ~ctrl_ff[`SIC_CTL_RESET];
    end
  end

  // One line per code; code zero drives nothing and code 2 is SMI.
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : gLine
      // Select code that owns this line, held at the field's own width.
      localparam [3:0] LINE_CODE = gi;
      always @(posedge mclk)
      begin
        if (!resetn)
        begin
          irqLines_ff[gi]  <= 1'b0;
          funcLines_ff[gi] <= 1'b0;
        end
        else
        begin
          irqLines_ff[gi]  <= (gi != 0) & pending & ~toPci &
                              (isaSel == LINE_CODE);
          funcLines_ff[gi] <= (gi != 0) & ioCard & ~cardIrqN &
                              (funcSel == LINE_CODE);
        end
      end
    end
  endgenerate

  // ***********************************************
  // Outputs
  // ***********************************************
  assign avsReadData    = rdData_ff;
  assign avsWaitRequest = wait_ff;
  assign cardResetOut   = cardRst_ff;
  assign changeIrqPci   = irqPci_ff;
  assign changeIrqLines = irqLines_ff;
  assign funcIrqLines   = funcLines_ff;

endmodule

// [test/sic_socket_irq_props.sv]
// Port checker for the socket status-change block, bound to its top module.
`timescale 1ns/1ns
module sic_socket_irq_props
(
  // Clock, reset and register bus.
  input wire        mclk,
  input wire        resetn,
  input wire [3:0]  avsAddress,
  input wire        avsRead,
  input wire        avsWrite,
  input wire [31:0] avsReadData,
  input wire        avsWaitRequest,
  // Reset pin, card line and routed outputs.
  input wire        globalResetPin,
  input wire        cardIrqN,
  input wire        cardResetOut,
  input wire        changeIrqPci,
  input wire [15:0] changeIrqLines,
  input wire [15:0] funcIrqLines
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_reset_hold_card: assert property ($rose(resetn) |-> cardResetOut)
    else $error("card reset not held after release");
  a_wait_one_cycle: assert property (!avsWaitRequest |=> avsWaitRequest)
    else $error("waitrequest low too long");
  a_wait_has_cause: assert property ($fell(avsWaitRequest)
    |-> $past(avsRead || avsWrite)) else $error("answer without request");
  a_flag_reserved_zero: assert property (avsRead && !avsWaitRequest && avsAddress == 4'h4
    |-> avsReadData[31:4] == 28'h0000000) else $error("reserved flag bits set");
  a_pci_excludes_lines: assert property (changeIrqPci |-> changeIrqLines == 16'h0000)
    else $error("change interrupt on two routes");
  a_lines_one_hot: assert property ($onehot0(changeIrqLines) && !changeIrqLines[0])
    else $error("bad change line pattern");
  a_func_needs_card: assert property (|funcIrqLines
    |-> $onehot(funcIrqLines) && !funcIrqLines[0] && $past(!cardIrqN))
    else $error("functional line without card request");
  a_global_reset_pin_clears_all: assert property (globalResetPin [*3]
    |-> cardResetOut && !changeIrqPci && changeIrqLines == 16'h0000
    && funcIrqLines == 16'h0000) else $error("global reset left state");
  c_pci: cover property (changeIrqPci);
  c_lines: cover property (|changeIrqLines);
  c_func: cover property (|funcIrqLines);
endmodule
bind sic_socket_irq sic_socket_irq_props chk_u (.mclk, .resetn, .avsAddress, .avsRead, .avsWrite,
  .avsReadData, .avsWaitRequest, .globalResetPin, .cardIrqN, .cardResetOut, .changeIrqPci,
  .changeIrqLines, .funcIrqLines);

// [test/sic_card_model.sv]
// Behavioural 16-bit card that drives the socket status pins.
`timescale 1ns/1ns
module sic_card_model
(
  // Clock and what the bench wants the card to show.
  input  wire logic mclk,
  input  wire logic wantOut,
  input  wire logic wantReady,
  input  wire logic wantLow,
  input  wire logic wantStatus,
  input  wire logic wantIrq,
  // Card pins.
  output logic      cardDetectOneN,
  output logic      cardDetectTwoN,
  output logic      cardReady,
  output logic      batteryVoltageOne,
  output logic      batteryVoltageTwo,
  output logic      cardStatusLineN,
  output logic      cardIrqN
);
  // A seated, idle card with a good battery at time zero.
  initial {cardDetectOneN, cardDetectTwoN, cardReady, batteryVoltageOne} = 4'h1;
  initial {batteryVoltageTwo, cardStatusLineN, cardIrqN} = 3'h7;
  // Pins move one edge after the wish, as a real card lags its host.
  always @(posedge mclk)
  begin
    cardDetectOneN    <= wantOut;
    cardDetectTwoN    <= wantOut;
    cardReady         <= wantReady;
    batteryVoltageOne <= 1'b1;
    batteryVoltageTwo <= !wantLow;
    cardStatusLineN   <= !wantStatus;
    cardIrqN          <= !wantIrq;
  end
endmodule

// [test/sic_socket_irq_tb.sv]
// Self-checking bench for the socket status-change block.
`timescale 1ns/1ns
module sic_socket_irq_tb;
  logic        mclk = 0, resetn = 0, avsRead = 0, avsWrite = 0, globalResetPin = 0;
  logic        busResetPin = 0, wantOut = 0, wantReady = 0, wantLow = 0, wantStatus = 0;
  logic        wantIrq = 0, cdOne, cdTwo, rdy, bvOne, bvTwo, stsN, irqN;
  logic        cardResetOut, changeIrqPci;
  logic [3:0]  avsAddress = 4'h0;
  logic [31:0] avsWriteData = 32'h0, avsReadData, rdv;
  logic        avsWaitRequest;
  logic [15:0] changeIrqLines, funcIrqLines;
  int          num_errors = 0, checks_done = 0, seed = 32'h36EE6A66;
  always #20 mclk = !mclk;
  sic_card_model card_u (.mclk, .wantOut, .wantReady, .wantLow, .wantStatus, .wantIrq,
    .cardDetectOneN(cdOne), .cardDetectTwoN(cdTwo), .cardReady(rdy), .batteryVoltageOne(bvOne),
    .batteryVoltageTwo(bvTwo), .cardStatusLineN(stsN), .cardIrqN(irqN));
  sic_socket_irq dut_u (.mclk, .resetn, .avsAddress, .avsRead, .avsWrite, .avsWriteData,
    .avsByteEnable(4'h3), .avsReadData, .avsWaitRequest, .globalResetPin, .busResetPin,
    .cardDetectOneN(cdOne), .cardDetectTwoN(cdTwo), .cardReady(rdy), .batteryVoltageOne(bvOne),
    .batteryVoltageTwo(bvTwo), .cardStatusLineN(stsN), .cardIrqN(irqN), .cardResetOut,
    .changeIrqPci, .changeIrqLines, .funcIrqLines);
  task automatic summarize;
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want)
    begin
      num_errors++;
      $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // One Avalon cycle; random junk rides in the ignored upper lanes.
  task automatic bus(input logic wr, input logic [3:0] adr, input logic [31:0] wd);
    int n;
    logic [31:0] r;
    r = $random(seed);
    n = 0;
    avsAddress <= adr;
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= {r[15:0], wd[15:0]};
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (avsWaitRequest !== 1'b0 && n < 40);
    if (n >= 40)
    begin
      num_errors++;
      summarize();
    end
    rdv = avsReadData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rdchk(input logic [3:0] adr, input logic [31:0] want);
    bus(1'b0, adr, 32'h0);
    check(rdv, want);
  endtask
  initial
  begin
    wt(20);
    resetn <= 1'b1;
    wt(1);
    check(32'(cardResetOut), 32'h1);
    rdchk(4'h0, 32'h0);
    rdchk(4'h8, 32'h0);
    rdchk(4'hC, 32'h0);
    bus(1'b1, 4'h0, 32'h40);
    wt(3);
    check(32'(cardResetOut), 32'h0);
    wantOut <= 1'b1;
    wt(4);
    rdchk(4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'hF);
    wantReady <= 1'b1;
    wt(4);
    check(32'(changeIrqPci), 32'h1);
    rdchk(4'h4, 32'h4);
    rdchk(4'h4, 32'h0);
    wt(3);
    check(32'(changeIrqPci), 32'h0);
    bus(1'b1, 4'h8, 32'h20F);
    wantOut <= 1'b0;
    wantLow <= 1'b1;
    wt(4);
    rdchk(4'h4, 32'hA);
    bus(1'b1, 4'h4, 32'h8);
    rdchk(4'h4, 32'h2);
    wantLow <= 1'b0;
    bus(1'b1, 4'h4, 32'h2);
    bus(1'b1, 4'h0, 32'h41);
    for (int m = 1; m < 16; m++)
    begin
      bus(1'b1, 4'h8, 32'h20F | (m << 4));
      wantOut <= !wantOut;
      wt(4);
      check(32'(changeIrqLines), 32'h1 << m);
      bus(1'b1, 4'h4, 32'h8);
    end
    wantOut <= !wantOut;
    bus(1'b1, 4'h0, 32'h51);
    wt(3);
    check(32'(changeIrqPci), 32'h1);
    bus(1'b1, 4'h8, 32'h31F);
    wt(3);
    check(32'(changeIrqLines), 32'h2);
    bus(1'b1, 4'h8, 32'h10F);
    wt(3);
    check(32'(changeIrqPci), 32'h1);
    rdchk(4'h4, 32'h8);
    bus(1'b1, 4'h0, 32'hC0);
    wantStatus <= 1'b1;
    wt(4);
    rdchk(4'h4, 32'h1);
    wantStatus <= 1'b0;
    wt(3);
    rdchk(4'h4, 32'h0);
    wantIrq <= 1'b1;
    for (int n = 1; n < 16; n++)
    begin
      bus(1'b1, 4'h0, 32'h60 | n);
      wt(3);
      check(32'(funcIrqLines), 32'h1 << n);
    end
    wantIrq <= 1'b0;
    wantReady <= 1'b0;
    wt(3);
    wantReady <= 1'b1;
    wt(4);
    rdchk(4'h4, 32'h0);
    bus(1'b1, 4'h8, 32'h40F);
    busResetPin <= 1'b1;
    wt(1);
    busResetPin <= 1'b0;
    wt(3);
    check(32'(cardResetOut), 32'h0);
    rdchk(4'h8, 32'h400);
    bus(1'b1, 4'h8, 32'h0);
    busResetPin <= 1'b1;
    wt(1);
    busResetPin <= 1'b0;
    wt(3);
    check(32'(cardResetOut), 32'h1);
    bus(1'b1, 4'h8, 32'h40F);
    globalResetPin <= 1'b1;
    wt(4);
    globalResetPin <= 1'b0;
    rdchk(4'h8, 32'h0);
    summarize();
  end
endmodule
